// >>> rpm_pkg.sv
package rpm_pkg;

    // ------------------------------------------------------------------
    // Clock and settle timing
    // ------------------------------------------------------------------
    localparam int unsigned CORE_CLK_MHZ   = 40;
    localparam int unsigned SETTLE_TIME_US = 100;
    // Exact product, so no rounding is needed for the least hold time
    localparam int unsigned SETTLE_CYCLES  = SETTLE_TIME_US * CORE_CLK_MHZ;
    localparam int unsigned CNT_W          = 12;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 12'h001;
    localparam logic [CNT_W-1:0] CNT_LAST  = CNT_W'(SETTLE_CYCLES - 1);

    // ------------------------------------------------------------------
    // Clock multiplier seen by baud and square-wave dividers
    // ------------------------------------------------------------------
    localparam logic [3:0] RATIO_OFF   = 4'h1;
    localparam logic [3:0] RATIO_ON    = 4'h8;
    localparam logic       PLL_DEFAULT = 1'b1;

    // ------------------------------------------------------------------
    // Sequencer states and reset sources
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_HOLD   = 3'b001,
        ST_SETTLE = 3'b010,
        ST_RUN    = 3'b100
    } rpm_state_e;

    typedef struct packed {
        logic powerOn;
        logic brownOut;
        logic external;
        logic software;
    } rpm_src_s;

endpackage : rpm_pkg

// >>> rpm_settle_counter.sv
`timescale 1ns/1ps
module rpm_settle_counter
    import rpm_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic run,
    output logic      done_q
);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic             done_d;

    // Counting on the crystal clock keeps the hold independent of PLL state
    always_comb begin
        count_d = CNT_ZERO;
        done_d  = 1'b0;
        if (run) begin
            if (count_q == CNT_LAST) begin
                count_d = count_q;
                done_d  = 1'b1;
            end else begin
                count_d = count_q + CNT_ONE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            count_q <= CNT_ZERO;
            done_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            done_q  <= done_d;
        end
    end

endmodule : rpm_settle_counter

// >>> rpm_reset_ctrl.sv
`timescale 1ns/1ps
module rpm_reset_ctrl
    import rpm_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic extResetHi,
    input  wire logic brownOut,
    input  wire logic swModeWrite,
    input  wire logic swModeVal,
    input  wire logic swResetReq,
    output logic      coreResetN_q,
    output logic      pllEnable_q,
    output logic      reqMode_q,
    output logic [3:0] clkRatio_q
);

    // ------------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------------
    rpm_src_s   src;
    logic       anySrc;
    logic       hardSrc;
    rpm_state_e state_q;
    rpm_state_e state_d;
    logic       coreResetN_d;
    logic       pllEnable_d;
    logic       reqMode_d;
    logic [3:0] clkRatio_d;
    logic       settleDone;

    always_comb begin
        src.powerOn  = ~nrst;
        src.brownOut = brownOut;
        src.external = extResetHi;
        src.software = swResetReq;
        anySrc  = src.powerOn | src.brownOut | src.external | src.software;
        hardSrc = src.powerOn | src.brownOut | src.external;
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_d      = state_q;
        coreResetN_d = 1'b0;
        if (anySrc) begin
            state_d = ST_HOLD;
        end else begin
            unique case (state_q)
                ST_HOLD: begin
                    state_d = ST_SETTLE;
                end
                ST_SETTLE: begin
                    if (settleDone) begin
                        state_d      = ST_RUN;
                        coreResetN_d = 1'b1;
                    end
                end
                ST_RUN: begin
                    coreResetN_d = 1'b1;
                end
                default: begin
                    state_d = ST_HOLD;
                end
            endcase
        end
    end

    rpm_settle_counter u_settle (
        .core_clk (core_clk),
        .nrst     (nrst),
        .run      (state_q == ST_SETTLE),
        .done_q   (settleDone)
    );

    // ------------------------------------------------------------------
    // PLL mode
    // ------------------------------------------------------------------
    // A hard source wins over a software reset arriving in the same cycle
    always_comb begin
        reqMode_d   = reqMode_q;
        pllEnable_d = pllEnable_q;
        if (swModeWrite) begin
            reqMode_d = swModeVal;
        end
        if (hardSrc) begin
            pllEnable_d = PLL_DEFAULT;
        end else if (src.software) begin
            pllEnable_d = reqMode_q;
        end
        clkRatio_d = pllEnable_d ? RATIO_ON : RATIO_OFF;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_q      <= ST_HOLD;
            coreResetN_q <= 1'b0;
            pllEnable_q  <= PLL_DEFAULT;
            reqMode_q    <= PLL_DEFAULT;
            clkRatio_q   <= RATIO_ON;
        end else begin
            state_q      <= state_d;
            coreResetN_q <= coreResetN_d;
            pllEnable_q  <= pllEnable_d;
            reqMode_q    <= reqMode_d;
            clkRatio_q   <= clkRatio_d;
        end
    end

    // ------------------------------------------------------------------
    // Hold length monitor
    // ------------------------------------------------------------------
    // Cycles since the last reset source, saturating at all ones; lets the
    // full settle hold be checked instead of only its first few cycles
    logic [CNT_W-1:0] holdCnt_q;
    logic [CNT_W-1:0] holdCnt_d;

    always_comb begin
        holdCnt_d = holdCnt_q;
        if (anySrc) begin
            holdCnt_d = CNT_ZERO;
        end else if (holdCnt_q != '1) begin
            holdCnt_d = holdCnt_q + CNT_ONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            holdCnt_q <= CNT_ZERO;
        end else begin
            holdCnt_q <= holdCnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_ext_reset_hold: assert property (@(posedge core_clk)
        extResetHi |=> !coreResetN_q)
        else $error("core left reset while external reset high");

    a_por_reset_hold: assert property (@(posedge core_clk)
        !nrst |=> !coreResetN_q && pllEnable_q)
        else $error("power-on reset did not hold core with PLL on");

    a_brown_default: assert property (@(posedge core_clk) disable iff (!nrst)
        brownOut |=> !coreResetN_q && pllEnable_q)
        else $error("brown-out did not restore default mode");

    a_ratio_off: assert property (@(posedge core_clk) disable iff (!nrst)
        !pllEnable_q |-> clkRatio_q == RATIO_OFF)
        else $error("multiplier wrong with PLL off");

    a_ratio_on: assert property (@(posedge core_clk) disable iff (!nrst)
        pllEnable_q |-> clkRatio_q == RATIO_ON)
        else $error("multiplier wrong with PLL on");

    a_mode_run_stable: assert property (@(posedge core_clk) disable iff (!nrst)
        $changed(pllEnable_q) |-> !coreResetN_q ##1 !coreResetN_q)
        else $error("PLL mode changed outside reset");

    a_release_after: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(coreResetN_q) |-> $past(settleDone) && $past(state_q) == ST_SETTLE)
        else $error("core released before PLL settled");

    a_settle_min: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(coreResetN_q) |-> !coreResetN_q [*8])
        else $error("settle hold too short");

    a_mode_write: assert property (@(posedge core_clk) disable iff (!nrst)
        swModeWrite |=> reqMode_q == $past(swModeVal))
        else $error("requested mode not stored");

    a_sw_reset_mode: assert property (@(posedge core_clk) disable iff (!nrst)
        (swResetReq && !extResetHi && !brownOut) |=> !coreResetN_q && pllEnable_q == $past(reqMode_q))
        else $error("software reset did not apply requested mode");

    a_hold_length: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(coreResetN_q) |-> holdCnt_q > CNT_LAST)
        else $error("core released before full settle count");

    a_run_stays: assert property (@(posedge core_clk) disable iff (!nrst)
        (coreResetN_q && !anySrc) |=> coreResetN_q)
        else $error("core entered reset with no source");

    a_sw_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        swResetReq |=> !coreResetN_q)
        else $error("software reset did not hold core");

    a_mode_no_source: assert property (@(posedge core_clk) disable iff (!nrst)
        !anySrc |=> $stable(pllEnable_q))
        else $error("PLL mode changed without a reset");

    a_req_kept: assert property (@(posedge core_clk) disable iff (!nrst)
        !swModeWrite |=> $stable(reqMode_q))
        else $error("requested mode changed without a write");

    a_ext_default: assert property (@(posedge core_clk) disable iff (!nrst)
        extResetHi |=> pllEnable_q == PLL_DEFAULT)
        else $error("external reset did not restore default mode");

    a_core_run_state: assert property (@(posedge core_clk) disable iff (!nrst)
        coreResetN_q |-> state_q == ST_RUN)
        else $error("core out of reset outside run state");

    a_hold_to_settle: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_q == ST_HOLD && !anySrc) |=> state_q == ST_SETTLE)
        else $error("hold did not move on to settle");

    a_settle_done_state: assert property (@(posedge core_clk) disable iff (!nrst)
        settleDone |-> $past(state_q) == ST_SETTLE)
        else $error("settle done outside settle state");

endmodule : rpm_reset_ctrl

// >>> rpm_button_model.sv
`timescale 1ns/1ps
module rpm_button_model (
    input  wire logic core_clk,
    input  wire logic press,
    output logic      extResetHi
);
    // Unpressed line sits low; the line starts low before the first edge, but an unconnected press is not tied down
    logic pressQ = 1'b0;
    // Button moves just after the edge, active high while held
    always @(posedge core_clk) pressQ <= press;
    assign extResetHi = pressQ;
endmodule : rpm_button_model

// >>> tb_reset_pll_mode_control.sv
`timescale 1ns/1ps
module tb_reset_pll_mode_control;
    import rpm_pkg::*;
    logic       core_clk, nrst, brownOut, swModeWrite, swModeVal, swResetReq, press;
    logic       extResetHi, coreResetN_q, pllEnable_q, reqMode_q;
    logic [3:0] clkRatio_q;
    int         fail_count = 0;
    int         compares = 0;

    rpm_button_model btn (.core_clk(core_clk), .press(press), .extResetHi(extResetHi));
    rpm_reset_ctrl DUT (.core_clk(core_clk), .nrst(nrst), .extResetHi(extResetHi), .brownOut(brownOut),
        .swModeWrite(swModeWrite), .swModeVal(swModeVal), .swResetReq(swResetReq),
        .coreResetN_q(coreResetN_q), .pllEnable_q(pllEnable_q), .reqMode_q(reqMode_q),
        .clkRatio_q(clkRatio_q));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic wrap_up;
        $display("Counts: compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    task automatic check1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check1

    task automatic check4(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check4

    task automatic checkCount(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask : checkCount

    // Count cycles until the core leaves reset; a hang ends the run
    task automatic waitRelease;
        int n;
        n = 0;
        while (coreResetN_q !== 1'b1) begin
            @(negedge core_clk);
            n++;
            if (n > SETTLE_CYCLES + 50) begin
                fail_count++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, n, SETTLE_CYCLES);
                wrap_up();
            end
        end
        checkCount(n, SETTLE_CYCLES, SETTLE_CYCLES + 4);
    endtask : waitRelease

    task automatic pulse(ref logic sig, input int cycles);
        sig = 1'b1;
        repeat (cycles) @(negedge core_clk);
        check1(coreResetN_q, 1'b0);
        sig = 1'b0;
        @(negedge core_clk);
    endtask : pulse

    task automatic testPowerOn;
        check1(coreResetN_q, 1'b0);
        nrst = 1'b1;
        waitRelease();
        check1(pllEnable_q, 1'b1);
        check4(clkRatio_q, RATIO_ON);
        $display("test power-on done");
    endtask : testPowerOn

    task automatic testSoftMode;
        swModeVal = 1'b0;
        swModeWrite = 1'b1;
        @(negedge core_clk);
        swModeWrite = 1'b0;
        repeat (5) @(negedge core_clk);
        check1(reqMode_q, 1'b0);
        check1(pllEnable_q, 1'b1);
        check1(coreResetN_q, 1'b1);
        pulse(swResetReq, 1);
        waitRelease();
        check1(pllEnable_q, 1'b0);
        check4(clkRatio_q, RATIO_OFF);
        $display("test software mode done");
    endtask : testSoftMode

    task automatic testExternal;
        pulse(press, 6);
        check1(coreResetN_q, 1'b0);
        waitRelease();
        check1(pllEnable_q, 1'b1);
        check4(clkRatio_q, RATIO_ON);
        $display("test external reset done");
    endtask : testExternal

    task automatic testBrownOut;
        swModeWrite = 1'b1;
        @(negedge core_clk);
        swModeWrite = 1'b0;
        // Both requests rise and fall together, so the hard source decides the mode
        swResetReq = 1'b1;
        brownOut = 1'b1;
        repeat (2) @(negedge core_clk);
        check1(coreResetN_q, 1'b0);
        swResetReq = 1'b0;
        brownOut = 1'b0;
        @(negedge core_clk);
        waitRelease();
        check1(pllEnable_q, 1'b1);
        swModeVal = 1'b1;
        swModeWrite = 1'b1;
        @(negedge core_clk);
        swModeWrite = 1'b0;
        check1(reqMode_q, 1'b1);
        check1(coreResetN_q, 1'b1);
        $display("test brown-out done");
    endtask : testBrownOut

    initial begin
        nrst = 1'b0;
        brownOut = 1'b0;
        swModeWrite = 1'b0;
        swModeVal = 1'b0;
        swResetReq = 1'b0;
        press = 1'b0;
        repeat (3) @(negedge core_clk);
        testPowerOn();
        testSoftMode();
        testExternal();
        testBrownOut();
        wrap_up();
    end
endmodule : tb_reset_pll_mode_control
